// *** hdl/uarx_pkg.sv ***
package uarx_pkg;

    localparam int SAMP_NORMAL   = 16;
    localparam int SAMP_DOUBLE   = 8;
    localparam int VOTE_FIRST_N  = 8;
    localparam int VOTE_FIRST_D  = 4;

    // APB register byte addresses
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_BAUD   = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_DATA   = 12'h00c;
    localparam logic [11:0] ADDR_IRQST  = 12'h010;
    localparam logic [11:0] ADDR_IRQMSK = 12'h014;

    // Control bit positions
    localparam int CTRL_RX_EN  = 0;
    localparam int CTRL_DBL    = 1;
    localparam int CTRL_PAR_EN = 2;
    localparam int CTRL_PAR_OD = 3;
    localparam int CTRL_LEN_LO = 4;

    // Status / interrupt bit positions
    localparam int ST_RXC = 0;
    localparam int ST_FE  = 1;
    localparam int ST_DOR = 2;
    localparam int ST_PE  = 3;

    localparam logic [15:0] BAUD_RESET = 16'h0000;
    localparam logic [2:0]  LEN_RESET  = 3'h3;
    localparam int          FIFO_DEPTH = 2;

    typedef struct packed {
        logic [7:0] data;
        logic       frame_err;
        logic       overrun;
        logic       parity_err;
    } uarx_frame_type;

    typedef struct packed {
        logic        rx_en;
        logic        dbl;
        logic        par_en;
        logic        par_odd;
        logic [2:0]  len_code;
        logic [15:0] baud;
    } uarx_cfg_type;

endpackage : uarx_pkg

// *** hdl/uarx_recover.sv ***
module uarx_recover (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     serial_rx_line,
    input  wire uarx_pkg::uarx_cfg_type   cfg,
    output logic                          frame_valid,
    output uarx_pkg::uarx_frame_type      frame_out,
    output logic                          start_seen
);

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_START = 4'b0010,
        S_BITS  = 4'b0100,
        S_STOP  = 4'b1000
    } uarx_st_type;

    typedef struct packed {
        logic [1:0]  sync;
        logic        prev;
        logic [15:0] div;
        uarx_st_type st;
        logic [4:0]  samp;
        logic [3:0]  bitn;
        logic [9:0]  shreg;
        logic [2:0]  votes;
        logic        valid;
        uarx_pkg::uarx_frame_type fr;
        logic        start;
    } uarx_rec_type;

    uarx_rec_type r_q, r_d;

    function automatic logic major(input logic [2:0] v);
        major = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : major

    logic       tick;
    logic [4:0] spb;
    logic [4:0] vfirst;
    logic [3:0] nbits;
    logic       rxs;
    logic       bitv;

    always_comb begin
        // Exact integer divisor: own rate error stays within its half share
        tick   = (r_q.div == cfg.baud);
        spb    = cfg.dbl ? 5'(uarx_pkg::SAMP_DOUBLE) : 5'(uarx_pkg::SAMP_NORMAL);
        vfirst = cfg.dbl ? 5'(uarx_pkg::VOTE_FIRST_D) : 5'(uarx_pkg::VOTE_FIRST_N);
        nbits  = 4'(cfg.len_code) + 4'h5 + (cfg.par_en ? 4'h1 : 4'h0);
        rxs    = r_q.sync[1];
        bitv   = major({rxs, r_q.votes[1:0]});
    end

    always_comb begin
        logic [9:0] al;
        logic [9:0] msk;
        al        = r_q.shreg >> (4'd10 - nbits);
        msk       = (10'h001 << (4'(cfg.len_code) + 4'h5)) - 10'h001;
        r_d       = r_q;
        r_d.sync  = {r_q.sync[0], serial_rx_line};
        r_d.valid = 1'b0;
        r_d.start = 1'b0;
        r_d.div   = tick ? 16'h0000 : r_q.div + 16'h0001;
        if (!cfg.rx_en) begin
            r_d.st   = S_IDLE;
            // Track the line so enabling on a low line gives no false edge
            r_d.prev = rxs;
        end else if (tick) begin
            r_d.prev = rxs;
            r_d.samp = r_q.samp + 5'h01;
            if (r_q.samp >= vfirst && r_q.samp < vfirst + 5'h03) begin
                r_d.votes = {r_q.votes[1:0], rxs};
            end
            case (r_q.st)
                S_IDLE: begin
                    if (r_q.prev && !rxs) begin
                        r_d.st   = S_START;
                        r_d.samp = 5'h02;
                    end
                end
                S_START: begin
                    if (r_q.samp == vfirst + 5'h02) begin
                        if (bitv) begin
                            r_d.st = S_IDLE;
                        end else begin
                            r_d.st    = S_BITS;
                            r_d.bitn  = 4'h0;
                            r_d.start = 1'b1;
                        end
                    end
                    if (r_q.samp == spb) begin
                        r_d.samp = 5'h01;
                    end
                end
                S_BITS: begin
                    if (r_q.samp == vfirst + 5'h02) begin
                        r_d.shreg = {bitv, r_q.shreg[9:1]};
                        r_d.bitn  = r_q.bitn + 4'h1;
                    end
                    if (r_q.samp == spb) begin
                        r_d.samp = 5'h01;
                        if (r_q.bitn == nbits) begin
                            r_d.st = S_STOP;
                        end
                    end
                end
                S_STOP: begin
                    if (r_q.samp == vfirst + 5'h02) begin
                        r_d.fr.frame_err = !bitv;
                        r_d.fr.data      = 8'(r_q.shreg >> (4'd10 - nbits));
                        if (!cfg.par_en) begin
                            r_d.fr.data = 8'(r_q.shreg >> (4'd10 - nbits));
                        end
                        r_d.valid = 1'b1;
                        r_d.st    = S_IDLE;
                    end
                end
                default: r_d.st = S_IDLE;
            endcase
        end
        if (r_d.valid) begin
            // Parity over data bits plus received parity bit
            r_d.fr.data = 8'(al & msk);
            r_d.fr.parity_err = cfg.par_en
                && ((^al) ^ cfg.par_odd);
            r_d.fr.overrun = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{sync: 2'b11, prev: 1'b1, st: S_IDLE, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    assign frame_valid = r_q.valid;
    assign frame_out   = r_q.fr;
    assign start_seen  = r_q.start;

    property p_stop_done;
        @(posedge pclk) disable iff (!presetn)
        r_q.valid |-> r_q.st == S_IDLE;
    endproperty
    a_stop_done: assert property (p_stop_done) else $error("not idle after stop");

    property p_fe;
        @(posedge pclk) disable iff (!presetn)
        (cfg.rx_en && tick && r_q.st == S_STOP && r_q.samp == vfirst + 5'h02)
            |=> r_q.fr.frame_err == !$past(bitv);
    endproperty
    a_fe: assert property (p_fe) else $error("frame error wrong");

    property p_reject;
        @(posedge pclk) disable iff (!presetn)
        (cfg.rx_en && tick && r_q.st == S_START && r_q.samp == vfirst + 5'h02 && bitv)
            |=> r_q.st == S_IDLE;
    endproperty
    a_reject: assert property (p_reject) else $error("noise start kept");

    property p_tick;
        @(posedge pclk) disable iff (!presetn)
        tick |=> r_q.div == 16'h0000;
    endproperty
    a_tick: assert property (p_tick) else $error("divider not reloaded");

endmodule : uarx_recover

// *** hdl/uarx_top.sv ***
// Summary of operation
// - Sample 16x, or 8x in double speed
// - Falling edge starts qualification, sample one
// - Qualify start with samples 8-10 or 4-6
// - Majority high rejects start as noise
// - Realign phase counter at every start
// - One state per frame part; a sample counter tracks position within each bit
// - Bit value is majority of centre three
// - Recover through first stop, ignore others
// - Stop voted zero sets frame error
// - Rearm right after stop voting samples
// - Each end takes half rate error
// - Error flags travel with their frame
// - Parity checked when enabled, stored with frame
// - Complete flag tracks unread; disable flushes
//
// Our own choices: the placing of the registers and the APB slave port.
module uarx_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serial_rx_line,
    output logic             irq
);

    typedef struct packed {
        uarx_pkg::uarx_cfg_type cfg;
        uarx_pkg::uarx_frame_type [uarx_pkg::FIFO_DEPTH-1:0] fifo;
        logic [1:0] count;
        logic       pend_ovr;
        logic       rwait;
        logic [3:0] ist;
        logic [3:0] imsk;
        logic [31:0] rdata;
    } uarx_top_type;

    uarx_top_type t_q, t_d;

    logic                     fv;
    uarx_pkg::uarx_frame_type fr;
    logic                     ss;

    uarx_recover u_rec (
        .pclk           (pclk),
        .presetn        (presetn),
        .serial_rx_line (serial_rx_line),
        .cfg            (t_q.cfg),
        .frame_valid    (fv),
        .frame_out      (fr),
        .start_seen     (ss)
    );

    ////////////////////////////////////////////////////////////////////////
    logic acc;
    logic wr;
    logic rd;
    logic mapped;

    always_comb begin
        acc    = psel && penable;
        wr     = acc && pwrite;
        // Registered read data costs one wait state; pop only on the first cycle
        rd     = acc && !pwrite && !t_q.rwait;
        mapped = paddr inside {uarx_pkg::ADDR_CTRL, uarx_pkg::ADDR_BAUD,
                               uarx_pkg::ADDR_STATUS, uarx_pkg::ADDR_DATA,
                               uarx_pkg::ADDR_IRQST, uarx_pkg::ADDR_IRQMSK};
    end

    assign pready  = !(acc && !pwrite) || t_q.rwait;
    assign pslverr = acc && !mapped;
    assign prdata  = t_q.rdata;

    always_comb begin
        logic       pop;
        logic       full;
        logic [3:0] ev;
        pop  = 1'b0;
        full = 1'b0;
        ev   = 4'h0;
        t_d  = t_q;
        t_d.rwait = rd;
        pop  = rd && paddr == uarx_pkg::ADDR_DATA && t_q.count != 2'h0;
        full = t_q.count == 2'(uarx_pkg::FIFO_DEPTH);
        // Buffer stays full: a new start while both entries wait and none is popped is an overrun
        if (ss && full && !pop) begin
            t_d.pend_ovr = 1'b1;
        end
        if (pop) begin
            t_d.fifo[0] = t_q.fifo[1];
            t_d.count   = t_q.count - 2'h1;
        end
        if (fv) begin
            if (t_d.count != 2'(uarx_pkg::FIFO_DEPTH)) begin
                t_d.fifo[t_d.count]         = fr;
                t_d.fifo[t_d.count].overrun = t_d.pend_ovr;
                t_d.count    = t_d.count + 2'h1;
                t_d.pend_ovr = 1'b0;
                ev[uarx_pkg::ST_RXC] = 1'b1;
                ev[uarx_pkg::ST_FE]  = fr.frame_err;
                ev[uarx_pkg::ST_PE]  = fr.parity_err;
            end else begin
                t_d.pend_ovr = 1'b1;
                ev[uarx_pkg::ST_DOR] = 1'b1;
            end
        end
        if (wr) begin
            case (paddr)
                uarx_pkg::ADDR_CTRL: begin
                    t_d.cfg.rx_en    = pwdata[uarx_pkg::CTRL_RX_EN];
                    t_d.cfg.dbl      = pwdata[uarx_pkg::CTRL_DBL];
                    t_d.cfg.par_en   = pwdata[uarx_pkg::CTRL_PAR_EN];
                    t_d.cfg.par_odd  = pwdata[uarx_pkg::CTRL_PAR_OD];
                    t_d.cfg.len_code = pwdata[uarx_pkg::CTRL_LEN_LO +: 3];
                end
                uarx_pkg::ADDR_BAUD:   t_d.cfg.baud = pwdata[15:0];
                uarx_pkg::ADDR_IRQST:  t_d.ist = t_q.ist & ~pwdata[3:0];
                uarx_pkg::ADDR_IRQMSK: t_d.imsk = pwdata[3:0];
                default: ;
            endcase
        end
        t_d.ist = t_d.ist | ev;
        if (!t_d.cfg.rx_en) begin
            t_d.count    = 2'h0;
            t_d.pend_ovr = 1'b0;
        end
        if (rd) begin
            case (paddr)
                uarx_pkg::ADDR_CTRL: t_d.rdata = 32'({t_q.cfg.len_code, t_q.cfg.par_odd,
                                          t_q.cfg.par_en, t_q.cfg.dbl, t_q.cfg.rx_en});
                uarx_pkg::ADDR_BAUD:   t_d.rdata = 32'(t_q.cfg.baud);
                // Flags of a frame already read are stale: hide them when empty
                uarx_pkg::ADDR_STATUS: t_d.rdata = (t_q.count == 2'h0) ? 32'h0000_0000 :
                                          32'({t_q.fifo[0].parity_err,
                                          t_q.fifo[0].overrun, t_q.fifo[0].frame_err,
                                          1'b1});
                uarx_pkg::ADDR_DATA:   t_d.rdata = 32'(t_q.fifo[0].data);
                uarx_pkg::ADDR_IRQST:  t_d.rdata = 32'(t_q.ist);
                uarx_pkg::ADDR_IRQMSK: t_d.rdata = 32'(t_q.imsk);
                default:               t_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_q <= '{cfg: '{len_code: uarx_pkg::LEN_RESET,
                            baud: uarx_pkg::BAUD_RESET, default: '0},
                     default: '0};
        end else begin
            t_q <= t_d;
        end
    end

    assign irq = |(t_q.ist & t_q.imsk);

    ////////////////////////////////////////////////////////////////////////
    property p_flush;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == uarx_pkg::ADDR_CTRL && !pwdata[uarx_pkg::CTRL_RX_EN])
            |=> t_q.count == 2'h0;
    endproperty
    a_flush: assert property (p_flush) else $error("flush failed");

    property p_store;
        @(posedge pclk) disable iff (!presetn)
        (fv && t_q.count == 2'h0 && t_q.cfg.rx_en && !wr)
            |=> t_q.count == 2'h1 && t_q.fifo[0].frame_err == $past(fr.frame_err);
    endproperty
    a_store: assert property (p_store) else $error("frame not stored");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        irq |-> (t_q.ist & t_q.imsk) != 4'h0;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");

    property p_pe_off;
        @(posedge pclk) disable iff (!presetn)
        (fv && !t_q.cfg.par_en) |-> !fr.parity_err;
    endproperty
    a_pe_off: assert property (p_pe_off) else $error("parity flagged while off");

endmodule : uarx_top

// *** sim/uarx_tx_model.sv ***
module uarx_tx_model (
    input  wire logic pclk,
    output logic      serial_rx_line
);
    timeunit 1ns;
    timeprecision 1ns;

    initial serial_rx_line = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Each level is held a whole number of pclk cycles; exact rate, no drift
    task automatic put(input logic b, input int cyc);
        serial_rx_line <= b;
        repeat (cyc) @(posedge pclk);
    endtask : put

    // Stop length above one period acts as extra stop bits
    task automatic send(input logic [7:0] d, input int nb, input int per, input int par,
                        input logic stop, input int stop_len);
        put(1'b0, per);
        for (int i = 0; i < nb; i++) begin
            put(d[i], per);
        end
        if (par >= 0) begin
            put(par[0], per);
        end
        put(stop, stop_len);
        if (!stop) begin
            put(1'b1, per);
        end
    endtask : send

    // Low pulse too short to survive the start vote
    task automatic glitch(input int low_cyc, input int per);
        put(1'b0, low_cyc);
        put(1'b1, per);
    endtask : glitch
endmodule : uarx_tx_model

// *** sim/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        serial_rx_line;
    logic        irq;
    logic [31:0] rd;
    logic [31:0] lfsr;
    logic [7:0]  m;
    int          err_count;
    int          comparisons;
    int          per;
    int          exp_q[$];

    uarx_top DUT (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .serial_rx_line (serial_rx_line),
        .irq            (irq)
    );

    uarx_tx_model tx (
        .pclk           (pclk),
        .serial_rx_line (serial_rx_line)
    );

    always #50 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // Read data is taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        check({31'h0, pslverr}, {31'h0, err});
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    ////////////////////////////////////////////////////////////////////////////////
    // Model entry: {overrun, parity error, frame error, data}
    task automatic frame(input logic [7:0] d, input int nb, input int par, input logic pe,
                         input logic stop, input int sl);
        exp_q.push_back({22'h0, pe, ~stop, d});
        tx.send(d, nb, per, par, stop, sl);
    endtask : frame

    task automatic drain;
        int e;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            apb(1'b0, uarx_pkg::ADDR_STATUS, 32'h0, 1'b0);
            check(rd, {28'h0, e[9], e[10], e[8], 1'b1});
            apb(1'b0, uarx_pkg::ADDR_DATA, 32'h0, 1'b0);
            check(rd, {24'h0, e[7:0]});
        end
        apb(1'b0, uarx_pkg::ADDR_STATUS, 32'h0, 1'b0);
        check(rd, 32'h0);
    endtask : drain

    initial begin
        #(64'd5_000_000);
        err_count++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        lfsr        = 32'hf252;
        err_count   = 0;
        comparisons = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, uarx_pkg::ADDR_CTRL, 32'h0, 1'b0);
        check(rd, 32'h30);
        apb(1'b0, uarx_pkg::ADDR_BAUD, 32'h0, 1'b0);
        check(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0, 1'b1);
        apb(1'b1, uarx_pkg::ADDR_BAUD, 32'h3, 1'b0);
        apb(1'b1, uarx_pkg::ADDR_IRQMSK, 32'h1, 1'b0);
        apb(1'b1, uarx_pkg::ADDR_CTRL, 32'h31, 1'b0);
        per = uarx_pkg::SAMP_NORMAL * 4;
        frame(8'ha5, 8, -1, 1'b0, 1'b1, per);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, uarx_pkg::ADDR_IRQST, 32'h1, 1'b0);
        check({31'h0, irq}, 32'h0);
        drain();
        frame(8'h3c, 8, -1, 1'b0, 1'b0, per);
        frame(8'hc3, 8, -1, 1'b0, 1'b1, per * 2);
        drain();
        // Stop cut short just after its vote samples, next start follows at once
        frame(8'h5a, 8, -1, 1'b0, 1'b1, per * 3 / 4);
        frame(8'h81, 8, -1, 1'b0, 1'b1, per);
        drain();
        tx.glitch(per * 6 / 16, per);
        drain();
        for (int code = 0; code < 4; code++) begin
            for (int odd = 0; odd < 2; odd++) begin
                apb(1'b1, uarx_pkg::ADDR_CTRL, 32'(5 | (code << 4) | (odd << 3)), 1'b0);
                lfsr = lfsr_next(lfsr);
                m = lfsr[7:0] & 8'((1 << (code + 5)) - 1);
                frame(m, code + 5, int'((^m) ^ odd[0] ^ code[0]), code[0], 1'b1, per);
                drain();
            end
        end
        apb(1'b1, uarx_pkg::ADDR_BAUD, 32'h1, 1'b0);
        apb(1'b1, uarx_pkg::ADDR_CTRL, 32'h33, 1'b0);
        per = uarx_pkg::SAMP_DOUBLE * 2;
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_next(lfsr);
            frame(lfsr[7:0], 8, -1, 1'b0, 1'b1, per);
        end
        drain();
        // Third frame meets a full buffer: lost, overrun rides on the next one
        frame(8'h96, 8, -1, 1'b0, 1'b1, per);
        frame(8'h69, 8, -1, 1'b0, 1'b1, per);
        frame(8'he7, 8, -1, 1'b0, 1'b1, per);
        void'(exp_q.pop_back());
        drain();
        frame(8'h7e, 8, -1, 1'b0, 1'b1, per);
        exp_q[exp_q.size() - 1] = exp_q[exp_q.size() - 1] | 32'h400;
        drain();
        frame(8'h11, 8, -1, 1'b0, 1'b1, per);
        frame(8'h22, 8, -1, 1'b0, 1'b1, per);
        apb(1'b1, uarx_pkg::ADDR_CTRL, 32'h32, 1'b0);
        exp_q.delete();
        drain();
        apb(1'b0, uarx_pkg::ADDR_IRQST, 32'h0, 1'b0);
        check(rd, 32'hf);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, uarx_pkg::ADDR_IRQMSK, 32'h0, 1'b0);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, uarx_pkg::ADDR_IRQST, 32'hf, 1'b0);
        apb(1'b0, uarx_pkg::ADDR_IRQST, 32'h0, 1'b0);
        check(rd, 32'h0);
        conclude();
    end
endmodule : testbench
